// File: inc/arbiter_pkg.sv
// Purpose: Shared constants and types for the four-way priority bus arbiter.
// Assumes: Four requesters, active-low requests, one shared active-low busy line.
// Notes:   The dispatch table layout is 15 entries of one grant line number each.

package arbiter_pkg;

   // ****************************************************************
   // Widths and sizes
   // ****************************************************************
   localparam int LINE_COUNT   = 4;
   localparam int TABLE_DEPTH  = 15;
   localparam int LINE_W       = 2;
   localparam int INDEX_W      = 4;

   // ****************************************************************
   // Levels and codes
   // ****************************************************************
   localparam logic [INDEX_W-1:0]    IDLE_INDEX = 4'hf;
   localparam logic [LINE_COUNT-1:0] REQ_NONE   = 4'hf;
   localparam logic [LINE_COUNT-1:0] GRANT_NONE = 4'h0;
   localparam logic [LINE_COUNT-1:0] GRANT_ONE  = 4'h1;
   localparam logic                  BUSY_FREE  = 1'h1;
   localparam logic [LINE_W-1:0]     LINE_LOW   = 2'h0;
   localparam logic [LINE_W-1:0]     LINE_TOP   = 2'h3;
   localparam logic [LINE_W-1:0]     LINE_NEXT  = 2'h2;

   // ****************************************************************
   // Default dispatch table, entry 14 first, entry 0 last
   // ****************************************************************
   localparam logic [TABLE_DEPTH-1:0][LINE_W-1:0] DISPATCH_DEFAULT = {
      2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0,
      2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3
   };

   // ****************************************************************
   // Arbiter phases
   // ****************************************************************
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_WAIT_BUSY,
      PH_WAIT_RELEASE,
      PH_WAIT_FREE
   } phase_t;

endpackage

// File: inc/dispatch_if.sv
// Purpose: Carries the request index to the dispatch table and the chosen line back.
// Assumes: Purely combinational lookup within one cycle.
// Notes:   The lookup side answers the index; the user side drives it.

`timescale 1ns/1ps
`default_nettype none

interface dispatch_if;
   import arbiter_pkg::*;

   logic [INDEX_W-1:0] index;
   logic [LINE_W-1:0]  dest;

   modport lookup (input index, output dest);
   modport user   (output index, input dest);
endinterface

`default_nettype wire

// File: src/dispatch_table.sv
// Purpose: Jump table that maps the 4-bit request pattern to a grant line.
// Assumes: Index comes from synchronised request levels.
// Notes:   The all-ones index has no entry; the caller stays idle on it.

`timescale 1ns/1ps
`default_nettype none

module dispatch_table
   import arbiter_pkg::*;
#(
   parameter logic [TABLE_DEPTH-1:0][LINE_W-1:0] TABLE = DISPATCH_DEFAULT
)(
   dispatch_if.lookup lk
);

   // ****************************************************************
   // Lookup
   // ****************************************************************
   // All lines are resolved at once from one table read, so no scan is needed.
   always_comb begin
      if (lk.index == IDLE_INDEX) begin
         lk.dest = LINE_LOW;
      end else begin
         lk.dest = TABLE[lk.index];
      end
   end

endmodule

`default_nettype wire

// File: src/four_way_priority_bus_arbiter.sv
// Purpose: Fixed-priority arbiter granting one shared bus to four requesters.
// Assumes: Requests and busy arrive asynchronously and are synchronised here.
// Notes:   Priority lives only in the dispatch table parameter.
//
// Summary of operation
// - In idle, the four synchronised requests form an index into the dispatch table.
// - Table entries zero to fourteen name a destination; all-ones means keep waiting.
// - Indices 1, 5, 9 and d start the second-priority grant sequence.
// - Default table gives line three top priority, then two, one, zero.
// - Priority changes only by loading different table entries.
// - Every step waits on a signal level, never on a cycle count.
// - A grant sequence has three substates, each testing one input.
// - With no request pending the arbiter stays idle and samples each clock.
// - All pending requests are resolved in one idle cycle, in parallel.
// - Requester holds busy while using the bus; release triggers re-arbitration.
// - All four grant sequences share one logic, differing only in line used.

`timescale 1ns/1ps
`default_nettype none

module four_way_priority_bus_arbiter
   import arbiter_pkg::*;
#(
   parameter logic [TABLE_DEPTH-1:0][LINE_W-1:0] DISPATCH_TABLE = DISPATCH_DEFAULT
)(
   // Clock and reset
   input  wire logic                  I_CLOCK,
   input  wire logic                  I_RST,
   // Requester pins
   input  wire logic [LINE_COUNT-1:0] I_BUS_REQUEST_N,
   input  wire logic                  I_SHARED_BUS_BUSY_N,
   // Grants
   output logic      [LINE_COUNT-1:0] O_BUS_GRANT
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [LINE_COUNT-1:0] req_meta;
      logic [LINE_COUNT-1:0] req_sync;
      logic                  free_meta;
      logic                  free_sync;
      phase_t                phase;
      logic [LINE_W-1:0]     line;
      logic [LINE_COUNT-1:0] grant;
   } state_t;

   localparam state_t STATE_RESET = '{
      req_meta:  REQ_NONE,
      req_sync:  REQ_NONE,
      free_meta: BUSY_FREE,
      free_sync: BUSY_FREE,
      phase:     PH_IDLE,
      line:      LINE_LOW,
      grant:     GRANT_NONE
   };

   localparam bit TABLE_IS_DEFAULT = (DISPATCH_TABLE == DISPATCH_DEFAULT);

   state_t state_reg;
   state_t state_next;

   dispatch_if dsp ();

   dispatch_table #(
      .TABLE (DISPATCH_TABLE)
   ) u_table (
      .lk (dsp.lookup)
   );

   // The table is ordered with line zero as the most significant index bit.
   assign dsp.index = {state_reg.req_sync[0], state_reg.req_sync[1],
                       state_reg.req_sync[2], state_reg.req_sync[3]};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      // Pins pass two flip-flops before any decision reads them.
      state_next.req_meta  = I_BUS_REQUEST_N;
      state_next.req_sync  = state_reg.req_meta;
      state_next.free_meta = I_SHARED_BUS_BUSY_N;
      state_next.free_sync = state_reg.free_meta;
      unique case (state_reg.phase)
         PH_IDLE: begin
            // Arbitration only starts once the previous owner has let go of busy.
            if (state_reg.free_sync && (dsp.index != IDLE_INDEX)) begin
               state_next.phase = PH_WAIT_BUSY;
               state_next.line  = dsp.dest;
            end
         end
         PH_WAIT_BUSY: begin
            // No timeout: a slow requester simply keeps its grant longer.
            if (!state_reg.free_sync) begin
               state_next.phase = PH_WAIT_RELEASE;
            end
         end
         PH_WAIT_RELEASE: begin
            if (state_reg.req_sync[state_reg.line]) begin
               state_next.phase = PH_WAIT_FREE;
            end
         end
         PH_WAIT_FREE: begin
            if (state_reg.free_sync) begin
               state_next.phase = PH_IDLE;
            end
         end
      endcase
      if (state_next.phase == PH_WAIT_BUSY) begin
         state_next.grant = GRANT_ONE << state_next.line;
      end else begin
         state_next.grant = GRANT_NONE;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign O_BUS_GRANT = state_reg.grant;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // The index must address every table entry plus the one idle pattern.
   if (TABLE_DEPTH != (1 << INDEX_W) - 1) begin : g_depth_check
      $error("Dispatch table depth does not match the request index width.");
   end
   // One index bit per line, and every line number must fit the LINE_W-bit line field.
   if (LINE_COUNT > (1 << LINE_W) || INDEX_W != LINE_COUNT) begin : g_line_check
      $error("Line count does not fit the line number or index width.");
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);

   sequence idle_with_request;
      state_reg.phase == PH_IDLE && state_reg.free_sync && dsp.index != IDLE_INDEX;
   endsequence

   sequence busy_taken;
      state_reg.phase == PH_WAIT_BUSY && !state_reg.free_sync
      ##1 state_reg.phase == PH_WAIT_RELEASE && O_BUS_GRANT == GRANT_NONE;
   endsequence

   sequence request_dropped;
      state_reg.req_sync[state_reg.line] ##1 state_reg.phase == PH_WAIT_FREE;
   endsequence

   reset_idle_a: assert property (
      $fell(I_RST) |-> state_reg.phase == PH_IDLE && O_BUS_GRANT == GRANT_NONE
   ) else $error("Arbiter was not idle on leaving reset.");

   idle_hold_a: assert property (
      state_reg.phase == PH_IDLE && dsp.index == IDLE_INDEX |=> state_reg.phase == PH_IDLE
   ) else $error("Arbiter left idle with no request pending.");

   dispatch_win_a: assert property (
      idle_with_request |=> state_reg.phase == PH_WAIT_BUSY
                            && state_reg.line == $past(dsp.dest)
                            && O_BUS_GRANT == (GRANT_ONE << state_reg.line)
   ) else $error("Dispatch did not grant the table's line.");

   grant_from_idle_a: assert property (
      $rose(O_BUS_GRANT != GRANT_NONE) |-> $past(state_reg.phase) == PH_IDLE
   ) else $error("Grant rose outside the idle dispatch step.");

   second_prio_a: assert property (
      (idle_with_request and (TABLE_IS_DEFAULT && !state_reg.req_sync[LINE_NEXT]
      && state_reg.req_sync[LINE_TOP])) |=> O_BUS_GRANT == (GRANT_ONE << LINE_NEXT)
   ) else $error("Second priority requester was not granted.");

   top_prio_a: assert property (
      (idle_with_request and (TABLE_IS_DEFAULT && !state_reg.req_sync[LINE_TOP]))
      |=> O_BUS_GRANT == (GRANT_ONE << LINE_TOP)
   ) else $error("Highest priority requester was not granted.");

   lowest_prio_a: assert property (
      (idle_with_request and (TABLE_IS_DEFAULT
      && state_reg.req_sync == ~(GRANT_ONE << LINE_LOW)))
      |=> O_BUS_GRANT == (GRANT_ONE << LINE_LOW)
   ) else $error("Lowest priority requester was not granted alone.");

   grant_single_a: assert property (
      $onehot0(O_BUS_GRANT) && ((O_BUS_GRANT != GRANT_NONE) == (state_reg.phase == PH_WAIT_BUSY))
   ) else $error("Grant outputs disagree with the grant phase.");

   grant_wait_a: assert property (
      state_reg.phase == PH_WAIT_BUSY && state_reg.free_sync
      |=> state_reg.phase == PH_WAIT_BUSY && $stable(O_BUS_GRANT)
   ) else $error("Grant dropped before busy was seen.");

   substate_walk_a: assert property (
      state_reg.phase == PH_WAIT_BUSY && !state_reg.free_sync |-> busy_taken
   ) else $error("Busy did not advance to the release substate.");

   release_walk_a: assert property (
      state_reg.phase == PH_WAIT_RELEASE |-> !state_reg.req_sync[state_reg.line]
      ##1 state_reg.phase == PH_WAIT_RELEASE or request_dropped
   ) else $error("Release substate misbehaved.");

   free_return_a: assert property (
      state_reg.phase == PH_WAIT_FREE && state_reg.free_sync |=> state_reg.phase == PH_IDLE
   ) else $error("Busy release did not return to idle.");

   busy_blocks_a: assert property (
      state_reg.phase == PH_IDLE && !state_reg.free_sync |=> O_BUS_GRANT == GRANT_NONE
   ) else $error("Grant issued while the bus was busy.");

endmodule

`default_nettype wire

// File: sim/requester_model.sv
// Purpose: Four requesters sharing the bus, as the arbiter sees them.
// Assumes: The busy line has a pull-up and this model is its only driver.
// Notes:   The bench sets the grant-to-busy latency, so prompt and slow answers occur.

`timescale 1ns/1ps
`default_nettype none

module requester_model (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // Bench control
   input  wire logic [3:0] i_set,
   input  wire logic [1:0] i_lat,
   // Arbiter side
   input  wire logic [3:0] i_grant,
   output logic      [3:0] o_req_n,
   output logic            o_busy_n,
   output logic      [3:0] o_pend
);
   logic [3:0] own_reg;
   logic [1:0] ph_reg;
   logic [2:0] cnt_reg;

   assign o_req_n = ~o_pend;

   // Pins move on the falling edge so the arbiter always samples settled levels.
   always @(negedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pend <= 4'h0;
         o_busy_n <= 1'h1;
         own_reg <= 4'h0;
         ph_reg <= 2'h0;
         cnt_reg <= 3'h0;
      end else begin
         o_pend <= (o_pend | i_set) & ~((ph_reg == 2'h2) ? own_reg : 4'h0);
         case (ph_reg)
            2'h0: if (i_grant != 4'h0) begin
               own_reg <= i_grant;
               cnt_reg <= {1'h0, i_lat};
               ph_reg <= 2'h1;
            end
            2'h1: if (cnt_reg == 3'h0) begin
               o_busy_n <= 1'h0;
               cnt_reg <= 3'h4;
               ph_reg <= 2'h2;
            end else cnt_reg <= cnt_reg - 3'h1;
            2'h2: if (cnt_reg == 3'h0) begin
               o_busy_n <= 1'h1;
               ph_reg <= 2'h3;
            end else cnt_reg <= cnt_reg - 3'h1;
            default: if (i_grant == 4'h0) ph_reg <= 2'h0;
         endcase
      end
   end
endmodule

`default_nettype wire

// File: sim/four_way_priority_bus_arbiter_tb_top.sv
// Purpose: Self-checking bench for the four-way priority bus arbiter.
// Assumes: Default dispatch table, so line three wins over two, one, zero.
// Notes:   Each request burst notes its expected grant order in a queue.

`timescale 1ns/1ps
`default_nettype none

module four_way_priority_bus_arbiter_tb_top;
   import arbiter_pkg::*;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic [3:0] set = 4'h0;
   logic [1:0] lat = 2'h2;
   logic [3:0] req_n, grant, pend, prev = 4'h0, m, e;
   logic       busy_n;
   logic [3:0] exp_q[$];
   int         checked = 0, fail_count = 0, seed = 73680, i;

   always #20 clk = ~clk;

   four_way_priority_bus_arbiter dut (.I_CLOCK(clk), .I_RST(rst), .I_BUS_REQUEST_N(req_n),
      .I_SHARED_BUS_BUSY_N(busy_n), .O_BUS_GRANT(grant));
   requester_model cpus (.i_clock(clk), .i_rst(rst), .i_set(set), .i_lat(lat),
      .i_grant(grant), .o_req_n(req_n), .o_busy_n(busy_n), .o_pend(pend));

   task print_verdict;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task compare(input string name, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   task issue(input logic [3:0] msk, input logic [1:0] l);
      for (int k = 3; k >= 0; k--) if (msk[k]) exp_q.push_back(4'h1 << k);
      @(negedge clk);
      set <= msk;
      lat <= l;
      @(negedge clk);
      set <= 4'h0;
   endtask

   task wait_until(input bit idle, input logic [3:0] g);
      for (int n = 0; n < 600; n++) begin
         @(negedge clk);
         if (idle ? (pend === 4'h0 && grant === 4'h0 && busy_n === 1'h1) : grant === g) begin
            repeat (3) @(negedge clk);
            return;
         end
      end
      $display("[ERR] wait expected %h seen %h", g, grant);
      fail_count++;
      print_verdict();
   endtask

   // ****************************************************************
   // Grant watcher
   // ****************************************************************
   always @(negedge clk) begin
      if (!rst && grant !== prev && grant !== 4'h0) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hx;
         compare("grant", e, grant);
      end
      prev <= grant;
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst <= 1'h0;
      repeat (10) @(negedge clk);
      compare("idle grant", 4'h0, grant);
      for (i = 1; i < 16; i++) begin
         issue(i[3:0], 2'h2);
         wait_until(1'b1, 4'h0);
      end
      issue(4'h1, 2'h0);
      wait_until(1'b0, 4'h1);
      issue(4'h8, 2'h3);
      wait_until(1'b1, 4'h0);
      // A reset in mid-grant abandons every request, so the pending notes go too.
      issue(4'hc, 2'h3);
      wait_until(1'b0, 4'h8);
      rst <= 1'h1;
      @(negedge clk);
      compare("reset grant", 4'h0, grant);
      exp_q.delete();
      rst <= 1'h0;
      repeat (2) @(negedge clk);
      compare("reset idle", 4'h0, grant);
      for (i = 0; i < 12; i++) begin
         m = $random(seed);
         if (m == 4'h0) m = 4'h6;
         issue(m, 2'($random(seed)));
         wait_until(1'b1, 4'h0);
      end
      compare("queue left", 4'h0, 4'(exp_q.size()));
      print_verdict();
   end
endmodule

`default_nettype wire
